// [common/isar_pkg.sv]
package isar_pkg;

    // ------------------------------------------------------------
    // Bit counting and address layout
    // ------------------------------------------------------------
    localparam logic [3:0] BIT_CNT_ZERO  = 4'h0;
    localparam logic [3:0] BIT_CNT_BYTE  = 4'h8;
    localparam logic [3:0] BIT_CNT_ACK   = 4'h9;
    localparam logic [4:0] TEN_BIT_HEAD  = 5'h1E;
    localparam int         ADDR_MSB      = 7;
    localparam int         ADDR_LSB      = 1;
    localparam int         RW_BIT        = 0;
    localparam int         HEAD_LSB      = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] OWN_ADDR_RST  = 8'h00;
    localparam logic [7:0] RX_BUF_RST    = 8'h00;
    localparam logic [7:0] SHIFT_RST     = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE   = 3'b000,
        PH_ADDR1  = 3'b001,
        PH_ADDR2  = 3'b010,
        PH_DATA   = 3'b011,
        PH_IGNORE = 3'b100
    } isar_phase_t;

    typedef struct packed {
        logic bufferFull;
        logic overrun;
        logic irqFlag;
        logic addrUpdatePending;
        logic rwStatus;
        logic startSeen;
        logic stopSeen;
    } isar_status_t;

    typedef struct packed {
        logic sclOut;
        logic sclOeN;
        logic sdaOut;
        logic sdaOeN;
    } isar_pins_t;

    localparam isar_status_t STATUS_RST = '{default: 1'b0};
    localparam isar_pins_t   PINS_RST   = '{sclOut: 1'b0, sclOeN: 1'b1, sdaOut: 1'b0, sdaOeN: 1'b1};

endpackage

// [hw/isar_sync.sv]
`timescale 1ns/1ps
module isar_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] metaQ;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            // Idle level of pulled-up lines, so no false edge after reset
            metaQ <= '1;
            dout  <= '1;
        end else begin
            metaQ <= din;
            dout  <= metaQ;
        end
    end

endmodule

// [hw/isar_core.sv]
// How it works
// - After enable, wait START, shift eight bits
// - Sample each bit on rising SCL
// - Compare bits 7:1 at eighth falling edge
// - Match, no overflow: load, flag, ACK, irq
// - Ten-bit head 11110 A9 A8 write
// - Both ten-bit write address bytes flag, hold SCL; the first only when not full or overrun
// - Second byte: release only on full match
// - Buffer read clears full at next falling SCL edge
// - Write match clears direction, loads address
// - No ACK while full or overrun set
// - Interrupt flag for every byte except an unmatched first address byte and bytes in the ignore phase, software clears
// - Full, start, stop bits tell sources apart
// - Enable hands the two pins to bus
`timescale 1ns/1ps
module isar_core
    import isar_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         sclClk,
    input  wire logic         sclIn,
    input  wire logic         sdaIn,
    output isar_pins_t        pins,
    input  wire logic         serialEnable,
    input  wire logic         tenBitMode,
    input  wire logic         ownAddrWe,
    input  wire logic [7:0]   ownAddrWdata,
    output logic      [7:0]   ownAddr,
    input  wire logic         rxBufRead,
    output logic      [7:0]   rxBuffer,
    input  wire logic         irqClear,
    input  wire logic         overrunClear,
    input  wire logic         irqEnable,
    output logic              irq,
    output isar_status_t      status
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        isar_phase_t  phase;
        logic [3:0]   bitCnt;
        logic         sclPrev;
        logic         sdaPrev;
        logic [7:0]   ownAddr;
        logic [7:0]   rxBuf;
        logic [7:0]   hiByte;
        logic         loMatch;
        logic         tenMatched;
        logic         holdPend;
        logic         holdSecond;
        logic         relOk;
        logic         readPend;
        logic         irqPend;
        isar_pins_t   pins;
        isar_status_t st;
        logic         irq;
    } isar_state_t;

    localparam isar_state_t STATE_RST = '{
        phase:      PH_IDLE,
        bitCnt:     BIT_CNT_ZERO,
        sclPrev:    1'b1,
        sdaPrev:    1'b1,
        ownAddr:    OWN_ADDR_RST,
        rxBuf:      RX_BUF_RST,
        hiByte:     RX_BUF_RST,
        loMatch:    1'b0,
        tenMatched: 1'b0,
        holdPend:   1'b0,
        holdSecond: 1'b0,
        relOk:      1'b0,
        readPend:   1'b0,
        irqPend:    1'b0,
        pins:       PINS_RST,
        st:         STATUS_RST,
        irq:        1'b0
    };

    isar_state_t q;
    isar_state_t d;
    logic [1:0]  pinSync;
    logic [7:0]  shiftQ;
    logic        sclS;
    logic        sdaS;

    // ------------------------------------------------------------
    // Link domain: shift register on SCL
    // ------------------------------------------------------------
    // Word is only read while SCL is low after the eighth bit,
    // when no rising edge can move it; that is the crossing.
    always_ff @(posedge sclClk or negedge rstn) begin
        if (!rstn) begin
            shiftQ <= SHIFT_RST;
        end else begin
            shiftQ <= {shiftQ[6:0], sdaIn};
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers for the core domain
    // ------------------------------------------------------------
    isar_sync #(.W (2)) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  ({sclIn, sdaIn}),
        .dout (pinSync)
    );

    assign sclS = pinSync[1];
    assign sdaS = pinSync[0];
    // ------------------------------------------------------------
    // Core next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic sclRise;
        logic sclFall;
        logic startCond;
        logic stopCond;
        logic ovf;
        logic hit7;
        logic tenHead;
        logic fullMatch;
        logic setBf;
        logic setOv;
        logic setIrq;
        sclRise   = 1'b0;
        sclFall   = 1'b0;
        startCond = 1'b0;
        stopCond  = 1'b0;
        ovf       = 1'b0;
        hit7      = 1'b0;
        tenHead   = 1'b0;
        fullMatch = 1'b0;
        setBf     = 1'b0;
        setOv     = 1'b0;
        setIrq    = 1'b0;
        d         = q;
        sclRise   = sclS & ~q.sclPrev;
        sclFall   = ~sclS & q.sclPrev;
        startCond = sclS & q.sclPrev & q.sdaPrev & ~sdaS;
        stopCond  = sclS & q.sclPrev & ~q.sdaPrev & sdaS;
        d.sclPrev = sclS;
        d.sdaPrev = sdaS;
        ovf     = q.st.bufferFull | q.st.overrun;
        hit7    = shiftQ[ADDR_MSB:ADDR_LSB] == q.ownAddr[ADDR_MSB:ADDR_LSB];
        tenHead = tenBitMode & (shiftQ[ADDR_MSB:HEAD_LSB] == TEN_BIT_HEAD);
        if (rxBufRead) begin
            d.readPend = 1'b1;
        end

        // --------------------------------------------------------
        // Own address writes and SCL release
        // --------------------------------------------------------
        // Ahead of the bus logic so a byte landing in the same cycle wins
        if (ownAddrWe) begin
            d.ownAddr              = ownAddrWdata;
            d.st.addrUpdatePending = 1'b0;
            fullMatch = q.loMatch & (q.hiByte[ADDR_MSB:ADDR_LSB] == ownAddrWdata[ADDR_MSB:ADDR_LSB]);
            if (q.holdSecond) begin
                d.relOk      = fullMatch;
                d.tenMatched = fullMatch;
            end else begin
                d.relOk = 1'b1;
            end
            if (!q.pins.sclOeN && (!q.holdSecond || fullMatch)) begin
                d.pins.sclOeN = 1'b1;
            end
        end

        // --------------------------------------------------------
        // Bus conditions
        // --------------------------------------------------------
        if (startCond) begin
            d.phase        = PH_ADDR1;
            d.bitCnt       = BIT_CNT_ZERO;
            d.st.startSeen = 1'b1;
            d.st.stopSeen  = 1'b0;
            d.pins.sdaOeN  = 1'b1;
            d.holdPend     = 1'b0;
        end else if (stopCond) begin
            d.phase        = PH_IDLE;
            d.st.stopSeen  = 1'b1;
            d.st.startSeen = 1'b0;
            d.tenMatched   = 1'b0;
            d.pins.sdaOeN  = 1'b1;
            d.holdPend     = 1'b0;
        end else if (q.phase != PH_IDLE) begin
            if (sclRise) begin
                d.bitCnt = q.bitCnt + 4'h1;
            end
            // Eighth falling edge: byte decision and ACK setup
            if (sclFall && q.bitCnt == BIT_CNT_BYTE) begin
                case (q.phase)
                    PH_ADDR1: begin
                        if (tenHead && hit7 && shiftQ[RW_BIT] && q.tenMatched) begin
                            // Read after repeated START: no address update
                            if (!ovf) begin
                                setBf           = 1'b1;
                                d.st.rwStatus   = 1'b1;
                                d.pins.sdaOeN   = 1'b0;
                            end
                            d.irqPend = 1'b1;
                            d.phase   = PH_IGNORE;
                        end else if (tenHead && hit7 && !shiftQ[RW_BIT]) begin
                            if (!ovf) begin
                                setBf                  = 1'b1;
                                d.st.addrUpdatePending = 1'b1;
                                d.hiByte               = shiftQ;
                                d.holdPend             = 1'b1;
                                d.holdSecond           = 1'b0;
                                d.relOk                = 1'b0;
                                d.pins.sdaOeN          = 1'b0;
                                d.phase                = PH_ADDR2;
                            end else begin
                                d.phase = PH_IGNORE;
                            end
                            d.irqPend = 1'b1;
                        end else if (!tenBitMode && hit7) begin
                            if (!ovf) begin
                                setBf         = 1'b1;
                                d.st.rwStatus = shiftQ[RW_BIT];
                                d.pins.sdaOeN = 1'b0;
                                d.phase       = shiftQ[RW_BIT] ? PH_IGNORE : PH_DATA;
                            end else begin
                                d.phase = PH_IGNORE;
                            end
                            d.irqPend = 1'b1;
                        end else begin
                            d.phase = PH_IGNORE;
                        end
                    end
                    PH_ADDR2: begin
                        // Flags and hold come whether or not it matched
                        d.loMatch              = shiftQ == q.ownAddr;
                        setBf                  = 1'b1;
                        d.st.addrUpdatePending = 1'b1;
                        d.holdPend             = 1'b1;
                        d.holdSecond           = 1'b1;
                        d.relOk                = 1'b0;
                        d.irqPend              = 1'b1;
                        if (shiftQ == q.ownAddr && !ovf) begin
                            d.st.rwStatus = 1'b0;
                            d.pins.sdaOeN = 1'b0;
                        end
                        d.phase = PH_DATA;
                    end
                    PH_DATA: begin
                        if (ovf) begin
                            setOv = 1'b1;
                        end else begin
                            setBf         = 1'b1;
                            d.pins.sdaOeN = 1'b0;
                        end
                        d.irqPend = 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
            // Ninth falling edge: end of ACK, interrupt, SCL hold
            if (sclFall && q.bitCnt == BIT_CNT_ACK) begin
                d.pins.sdaOeN = 1'b1;
                d.bitCnt      = BIT_CNT_ZERO;
                setIrq        = q.irqPend;
                d.irqPend     = 1'b0;
                if (q.holdPend && (q.st.addrUpdatePending || !q.relOk)) begin
                    d.pins.sclOeN = 1'b0;
                end
                if (q.holdPend && q.holdSecond && !q.loMatch) begin
                    d.phase = PH_IGNORE;
                end
                d.holdPend = 1'b0;
            end
        end

        // --------------------------------------------------------
        // Flags: set wins over every clear
        // --------------------------------------------------------
        if (setBf) begin
            d.rxBuf         = shiftQ;
            d.st.bufferFull = 1'b1;
            d.readPend      = 1'b0;
        end else if (q.readPend && sclFall) begin
            // Deferred so a stray read cannot look like fresh data
            d.st.bufferFull = 1'b0;
            d.readPend      = 1'b0;
        end
        if (setOv) begin
            d.st.overrun = 1'b1;
        end else if (overrunClear) begin
            d.st.overrun = 1'b0;
        end
        if (setIrq) begin
            d.st.irqFlag = 1'b1;
        end else if (irqClear) begin
            d.st.irqFlag = 1'b0;
        end
        d.irq = d.st.irqFlag & irqEnable;
        // --------------------------------------------------------
        // Disabled: pins go back to the port, bus logic idles
        // --------------------------------------------------------
        if (!serialEnable) begin
            d.phase       = PH_IDLE;
            d.bitCnt      = BIT_CNT_ZERO;
            d.holdPend    = 1'b0;
            d.irqPend     = 1'b0;
            d.tenMatched  = 1'b0;
            d.pins.sdaOeN = 1'b1;
            d.pins.sclOeN = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pins     = q.pins;
    assign ownAddr  = q.ownAddr;
    assign rxBuffer = q.rxBuf;
    assign irq      = q.irq;
    assign status   = q.st;

endmodule

// [bench/isar_sva.sv]
`timescale 1ns/1ps
module isar_sva
    import isar_pkg::*;
(
    input wire logic         clk,
    input wire logic         rstn,
    input wire logic         sclClk,
    input wire logic         sclIn,
    input wire logic         sdaIn,
    input wire isar_pins_t   pins,
    input wire logic         serialEnable,
    input wire logic         tenBitMode,
    input wire logic         ownAddrWe,
    input wire logic [7:0]   ownAddrWdata,
    input wire logic [7:0]   ownAddr,
    input wire logic         rxBufRead,
    input wire logic [7:0]   rxBuffer,
    input wire logic         irqClear,
    input wire logic         overrunClear,
    input wire logic         irqEnable,
    input wire logic         irq,
    input wire isar_status_t status
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_outs_low; pins.sclOut == 1'b0 && pins.sdaOut == 1'b0; endproperty
    property p_ack_ok; $fell(pins.sdaOeN) |-> status.bufferFull && !$past(status.overrun); endproperty
    property p_ack_len; $fell(pins.sdaOeN) |-> !pins.sdaOeN [*8]; endproperty
    property p_irq_on; $rose(status.irqFlag) && irqEnable |=> irq; endproperty
    property p_irq_src; irq == (status.irqFlag && $past(irqEnable)); endproperty
    property p_flag_time; $rose(status.irqFlag) |-> pins.sdaOeN; endproperty
    property p_hold;
        $rose(status.addrUpdatePending) |-> ##[1:100] (!pins.sclOeN || !status.addrUpdatePending);
    endproperty
    property p_upd_clr; status.addrUpdatePending && ownAddrWe |-> ##[1:2] !status.addrUpdatePending; endproperty
    property p_release;
        $rose(pins.sclOeN) && serialEnable |-> $past(ownAddrWe) || $past(ownAddrWe, 2) || $past(ownAddrWe, 3);
    endproperty
    property p_stop; $rose(status.stopSeen) |-> !status.startSeen; endproperty
    property p_off; $fell(serialEnable) |-> ##[1:4] pins.sclOeN && pins.sdaOeN; endproperty

    a_outs_low: assert property (p_outs_low)
        else $error("pin data level not low");
    a_ack_ok: assert property (p_ack_ok)
        else $error("ack without load or with overrun");
    a_ack_len: assert property (p_ack_len)
        else $error("ack pulse too short");
    a_irq_on: assert property (p_irq_on)
        else $error("irq not raised");
    a_irq_src: assert property (p_irq_src)
        else $error("irq without flag");
    a_flag_time: assert property (p_flag_time)
        else $error("flag set while ack driven");
    a_hold: assert property (p_hold)
        else $error("no clock hold on update");
    a_upd_clr: assert property (p_upd_clr)
        else $error("update pending not cleared");
    a_release: assert property (p_release)
        else $error("clock released without write");
    a_stop: assert property (p_stop)
        else $error("start bit left after stop");
    a_off: assert property (p_off)
        else $error("pins kept after disable");

    c_ack: cover property ($fell(pins.sdaOeN));
    c_hold: cover property ($rose(status.addrUpdatePending));
    c_stop: cover property ($rose(status.stopSeen));
    c_read: cover property ($rose(status.rwStatus));
endmodule

bind isar_core isar_sva u_sva (.*);

// [bench/isar_master.sv]
`timescale 1ns/1ps
module isar_master (
    output logic      sclM,
    output logic      sdaM,
    input  wire logic sclW,
    input  wire logic sdaW
);
    localparam time Q = 40ns;

    initial begin
        sclM = 1'b1;
        sdaM = 1'b1;
    end

    // Data moves only while the clock is low
    task automatic bitx(input logic v, output logic r);
        sdaM = v;
        #Q;
        sclM = 1'b1;
        wait (sclW === 1'b1);
        #(2 * Q);
        r = sdaW;
        sclM = 1'b0;
        #Q;
    endtask

    task automatic start();
        #3;
        sdaM = 1'b1;
        sclM = 1'b1;
        #Q;
        sdaM = 1'b0;
        #Q;
        sclM = 1'b0;
        #Q;
    endtask

    task automatic stop();
        sdaM = 1'b0;
        #Q;
        sclM = 1'b1;
        wait (sclW === 1'b1);
        #Q;
        sdaM = 1'b1;
        #(2 * Q);
    endtask

    task automatic xfer(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(b[i], r);
        end
        bitx(1'b1, ack);
    endtask
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import isar_pkg::*;
    logic         clk, rstn, serialEnable, tenBitMode, irqEnable, irq, ack;
    logic         ownAddrWe, rxBufRead, irqClear, overrunClear;
    logic   [7:0] ownAddrWdata, ownAddr, rxBuffer;
    logic         sclM, sdaM, sclW, sdaW;
    isar_pins_t   pins;
    isar_status_t status;
    int           fails, nChecks;

    // Open-drain wires with pull-ups
    assign sclW = sclM & pins.sclOeN;
    assign sdaW = sdaM & pins.sdaOeN;

    isar_master mst (.sclM(sclM), .sdaM(sdaM), .sclW(sclW), .sdaW(sdaW));

    isar_core dut (.clk(clk), .rstn(rstn), .sclClk(sclW), .sclIn(sclW), .sdaIn(sdaW), .pins(pins),
        .serialEnable(serialEnable), .tenBitMode(tenBitMode), .ownAddrWe(ownAddrWe),
        .ownAddrWdata(ownAddrWdata), .ownAddr(ownAddr), .rxBufRead(rxBufRead), .rxBuffer(rxBuffer),
        .irqClear(irqClear), .overrunClear(overrunClear), .irqEnable(irqEnable), .irq(irq),
        .status(status));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic sw(input logic [3:0] op, input logic [7:0] d);
        @(negedge clk);
        {overrunClear, irqClear, rxBufRead, ownAddrWe} = op;
        ownAddrWdata = d;
        @(negedge clk);
        {overrunClear, irqClear, rxBufRead, ownAddrWe} = 4'h0;
    endtask

    task automatic settle();
        repeat (5) @(negedge clk);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        #100000;
        fails++;
        report_and_stop();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rstn, serialEnable, tenBitMode, irqEnable} = 4'h0;
        {overrunClear, irqClear, rxBufRead, ownAddrWe} = 4'h0;
        ownAddrWdata = 8'h00;
        fails = 0;
        nChecks = 0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        chk(ownAddr, 8'h00);
        chk({1'b0, status}, 8'h00);
        serialEnable = 1'b1;
        irqEnable = 1'b1;
        sw(4'h1, 8'hB4);
        mst.start();
        mst.xfer(8'hB4, ack);
        settle();
        chk({6'h00, ack, irq}, 8'h01);
        chk(rxBuffer, 8'hB4);
        chk({1'b0, status}, 8'h52);
        sw(4'h6, 8'h00);
        chk({1'b0, status}, 8'h42);
        mst.xfer(8'h3C, ack);
        settle();
        chk({6'h00, ack, irq}, 8'h01);
        chk(rxBuffer, 8'h3C);
        chk({1'b0, status}, 8'h52);
        sw(4'h4, 8'h00);
        mst.xfer(8'hC3, ack);
        settle();
        chk({6'h00, ack, irq}, 8'h03);
        chk({1'b0, status}, 8'h72);
        mst.stop();
        settle();
        chk({1'b0, status}, 8'h71);
        mst.start();
        mst.xfer(8'hB4, ack);
        settle();
        chk({7'h00, ack}, 8'h01);
        chk(rxBuffer, 8'h3C);
        mst.stop();
        sw(4'hE, 8'h00);
        chk({1'b0, status}, 8'h41);
        mst.start();
        mst.xfer(8'h22, ack);
        settle();
        chk({7'h00, ack}, 8'h01);
        chk({1'b0, status}, 8'h02);
        mst.stop();
        @(negedge clk);
        tenBitMode = 1'b1;
        sw(4'h1, 8'hF2);
        mst.start();
        mst.xfer(8'hF2, ack);
        chk({7'h00, ack}, 8'h00);
        fork
            mst.xfer(8'h5C, ack);
            begin
                settle();
                chk({7'h00, pins.sclOeN}, 8'h00);
                chk({1'b0, status}, 8'h5A);
                sw(4'h1, 8'h5C);
                sw(4'h6, 8'h00);
            end
        join
        chk({7'h00, ack}, 8'h00);
        fork
            mst.xfer(8'h99, ack);
            begin
                settle();
                chk({7'h00, pins.sclOeN}, 8'h00);
                chk({1'b0, status}, 8'h5A);
                sw(4'h1, 8'hF2);
                sw(4'h6, 8'h00);
            end
        join
        chk({7'h00, ack}, 8'h00);
        chk(rxBuffer, 8'h99);
        chk(ownAddr, 8'hF2);
        sw(4'h6, 8'h00);
        mst.start();
        mst.xfer(8'hF3, ack);
        settle();
        chk({7'h00, ack}, 8'h00);
        chk(rxBuffer, 8'hF3);
        chk({1'b0, status}, 8'h56);
        mst.stop();
        @(negedge clk);
        serialEnable = 1'b0;
        settle();
        chk({6'h00, pins.sclOeN, pins.sdaOeN}, 8'h03);
        report_and_stop();
    end
endmodule
